// ==== logic/imb_pkg.sv ====
// constants for the interrupt enable mask bank: offsets, reset values, field positions
// assumes a byte-wide register port on the device system clock
// Function
// - low mask byte bits 0 to 4 let reference inputs one to five interrupt when 1, block when 0.
// - low mask byte bits 5 to 7 let reference inputs six to eight interrupt when 1, block when 0.
// - middle mask byte bits 0 to 5 let reference inputs nine to fourteen interrupt when 1.
// - middle byte bit 6 gates monitor reference failure and bit 7 monitor loop state change.
// - high byte bit 6 lets an auxiliary output path status change interrupt when 1.
// - high byte bit 4 lets an auxiliary path inputs failure interrupt when 1.
// - high byte bit 3 gates bipolar input two violations and bit 1 bipolar input one violations.
// - high byte bit 2 gates bipolar input two signal loss and bit 0 bipolar input one signal loss.
// - the low mask byte is read and write and resets to zero, so none of its sources is enabled.
package imb_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam int SRC_W = 24;

    localparam logic [ADDR_W-1:0] ADDR_LOW = 8'h43;
    localparam logic [ADDR_W-1:0] ADDR_MIDDLE = 8'h44;
    localparam logic [ADDR_W-1:0] ADDR_HIGH = 8'h45;

    localparam logic [BYTE_W-1:0] RESET_LOW = 8'h00;
    localparam logic [BYTE_W-1:0] RESET_MIDDLE = 8'h00;
    localparam logic [BYTE_W-1:0] RESET_HIGH = 8'h00;
    localparam logic [BYTE_W-1:0] READ_UNMAPPED = 8'h00;

    localparam logic [BYTE_W-1:0] WRITABLE_ALL = 8'hFF;
    // bits 7 and 5 of the high byte are fixed at zero
    localparam logic [BYTE_W-1:0] WRITABLE_HIGH = 8'h5F;

    // positions within the 24-bit source vector {high, middle, low}
    localparam int LOW_BASE = 0;
    localparam int MIDDLE_BASE = 8;
    localparam int HIGH_BASE = 16;

    localparam int REF_INPUT_ONE = 0;
    localparam int REF_INPUT_FIVE = 4;
    localparam int REF_INPUT_SIX = 5;
    localparam int REF_INPUT_EIGHT = 7;
    localparam int REF_INPUT_NINE = 8;
    localparam int REF_INPUT_FOURTEEN = 13;
    localparam int MONITOR_REF_FAIL_ENABLE = 14;
    localparam int MONITOR_LOOP_STATE_ENABLE = 15;
    localparam int BIPOLAR_IN1_SIGNAL_LOSS_ENABLE = 16;
    localparam int BIPOLAR_IN1_VIOLATION_ENABLE = 17;
    localparam int BIPOLAR_IN2_SIGNAL_LOSS_ENABLE = 18;
    localparam int BIPOLAR_IN2_VIOLATION_ENABLE = 19;
    localparam int AUX_INPUTS_FAIL_ENABLE = 20;
    localparam int AUX_PATH_STATUS_ENABLE = 22;
endpackage

// ==== logic/imb_mask_byte.sv ====
// one byte of interrupt enable mask with per-bit write permission
// assumes the write strobe and data come from logic on the same clock
`timescale 1ns/1ps
module imb_mask_byte #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITABLE = 8'hFF
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // write side
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    // stored mask
    output logic [7:0] value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    // fixed bits keep their reset value whatever is written
    always_comb begin
        value_next = value_reg;
        if (wr_stb) begin
            value_next = (wr_data & WRITABLE) | (RESET_VALUE & ~WRITABLE);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            value_reg <= RESET_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule

// ==== logic/imb_mask_bank.sv ====
// interrupt enable mask bank: three mask bytes gating 24 pending sources onto one request
// assumes pending status comes from the status unit on the same clock, so no synchroniser
`timescale 1ns/1ps
module imb_mask_bank (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    // sources from the status unit
    input wire logic [23:0] src_pending,
    // request to the interrupt pin logic
    output logic irq,
    output logic [23:0] src_request,
    output logic [23:0] mask_out
);
    logic wr_low;
    logic wr_middle;
    logic wr_high;
    logic [7:0] mask_low;
    logic [7:0] mask_middle;
    logic [7:0] mask_high;
    logic [23:0] mask_all;
    logic [7:0] rd_data_next;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic irq_reg;
    logic irq_next;
    logic [23:0] request_reg;
    logic [23:0] request_next;
    logic [23:0] mask_reg;

    assign wr_low = reg_wr && (reg_addr == imb_pkg::ADDR_LOW);
    assign wr_middle = reg_wr && (reg_addr == imb_pkg::ADDR_MIDDLE);
    assign wr_high = reg_wr && (reg_addr == imb_pkg::ADDR_HIGH);

    // low byte: reference inputs one to eight
    imb_mask_byte #(
        .RESET_VALUE(imb_pkg::RESET_LOW),
        .WRITABLE(imb_pkg::WRITABLE_ALL)
    ) u_low (
        .clock(clock),
        .arst_n(arst_n),
        .wr_stb(wr_low),
        .wr_data(reg_wr_data),
        .value(mask_low)
    );

    // middle byte: inputs nine to fourteen and the monitor loop
    imb_mask_byte #(
        .RESET_VALUE(imb_pkg::RESET_MIDDLE),
        .WRITABLE(imb_pkg::WRITABLE_ALL)
    ) u_middle (
        .clock(clock),
        .arst_n(arst_n),
        .wr_stb(wr_middle),
        .wr_data(reg_wr_data),
        .value(mask_middle)
    );

    // high byte: auxiliary path and bipolar inputs
    imb_mask_byte #(
        .RESET_VALUE(imb_pkg::RESET_HIGH),
        .WRITABLE(imb_pkg::WRITABLE_HIGH)
    ) u_high (
        .clock(clock),
        .arst_n(arst_n),
        .wr_stb(wr_high),
        .wr_data(reg_wr_data),
        .value(mask_high)
    );

    assign mask_all = {mask_high, mask_middle, mask_low};

    // read path, one cycle latency; unmapped addresses read zero
    always_comb begin
        rd_data_next = imb_pkg::READ_UNMAPPED;
        case (reg_addr)
            imb_pkg::ADDR_LOW: begin
                rd_data_next = mask_low;
            end
            imb_pkg::ADDR_MIDDLE: begin
                rd_data_next = mask_middle;
            end
            imb_pkg::ADDR_HIGH: begin
                rd_data_next = mask_high;
            end
            default: begin
                rd_data_next = imb_pkg::READ_UNMAPPED;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_reg <= imb_pkg::READ_UNMAPPED;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_rd;
            if (reg_rd) begin
                rd_data_reg <= rd_data_next;
            end
        end
    end

    // gating acts on the request only; pending status is never written here
    assign request_next = src_pending & mask_all;
    assign irq_next = |request_next;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            request_reg <= '0;
            irq_reg <= 1'b0;
            mask_reg <= '0;
        end else begin
            request_reg <= request_next;
            irq_reg <= irq_next;
            mask_reg <= mask_all;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;
    assign irq = irq_reg;
    assign src_request = request_reg;
    assign mask_out = mask_reg;

    // first cycle after reset release, for the reset value check
    logic after_reset_reg;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            after_reset_reg <= 1'b1;
        end else begin
            after_reset_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    a_low_first_five: assert property (
        (|(src_pending[imb_pkg::REF_INPUT_FIVE:imb_pkg::REF_INPUT_ONE]
           & mask_low[imb_pkg::REF_INPUT_FIVE:imb_pkg::REF_INPUT_ONE])) |=> irq)
        else $error("enabled input one to five did not raise the request");

    a_low_last_three: assert property (
        (src_pending[imb_pkg::REF_INPUT_EIGHT:imb_pkg::REF_INPUT_SIX] != 3'h0)
        && (src_pending[23:0] & ~(24'h0000E0)) == 24'h000000
        && mask_low[imb_pkg::REF_INPUT_EIGHT:imb_pkg::REF_INPUT_SIX] == 3'h0
        |=> !irq)
        else $error("blocked input six to eight raised the request");

    a_middle_inputs: assert property (
        wr_middle && (reg_wr_data & 8'h3F) != 8'h00
        ##1 (|(src_pending[imb_pkg::REF_INPUT_FOURTEEN:imb_pkg::REF_INPUT_NINE]
               & mask_middle[5:0])) |=> irq)
        else $error("enabled input nine to fourteen did not raise the request");

    a_monitor_gates: assert property (
        src_pending == (24'h1 << imb_pkg::MONITOR_LOOP_STATE_ENABLE)
        |=> irq == $past(mask_all[imb_pkg::MONITOR_LOOP_STATE_ENABLE]))
        else $error("monitor loop state gating wrong");

    a_monitor_fail: assert property (
        src_pending == (24'h1 << imb_pkg::MONITOR_REF_FAIL_ENABLE)
        |=> src_request[imb_pkg::MONITOR_REF_FAIL_ENABLE]
            == $past(mask_middle[6]))
        else $error("monitor reference failure gating wrong");

    a_aux_status: assert property (
        src_pending[imb_pkg::AUX_PATH_STATUS_ENABLE] && mask_high[6] |=> irq)
        else $error("aux status change did not raise the request");

    a_aux_fail: assert property (
        src_pending == (24'h1 << imb_pkg::AUX_INPUTS_FAIL_ENABLE) && !mask_high[4]
        |=> !irq && src_request == 24'h0)
        else $error("blocked aux inputs failure raised the request");

    a_bipolar_viol: assert property (
        1'b1 |=> src_request[imb_pkg::BIPOLAR_IN2_VIOLATION_ENABLE]
            == ($past(src_pending[imb_pkg::BIPOLAR_IN2_VIOLATION_ENABLE]) && $past(mask_high[3]))
        && src_request[imb_pkg::BIPOLAR_IN1_VIOLATION_ENABLE]
            == ($past(src_pending[imb_pkg::BIPOLAR_IN1_VIOLATION_ENABLE]) && $past(mask_high[1])))
        else $error("bipolar violation gating wrong");

    a_bipolar_loss: assert property (
        1'b1 |=> src_request[imb_pkg::BIPOLAR_IN2_SIGNAL_LOSS_ENABLE]
            == ($past(src_pending[imb_pkg::BIPOLAR_IN2_SIGNAL_LOSS_ENABLE]) && $past(mask_high[2]))
        && src_request[imb_pkg::BIPOLAR_IN1_SIGNAL_LOSS_ENABLE]
            == ($past(src_pending[imb_pkg::BIPOLAR_IN1_SIGNAL_LOSS_ENABLE]) && $past(mask_high[0])))
        else $error("bipolar signal loss gating wrong");

    a_low_reset_zero: assert property (
        after_reset_reg |-> mask_low == imb_pkg::RESET_LOW && !irq)
        else $error("low mask not zero after reset");

    a_low_write_read: assert property (
        wr_low ##1 (reg_rd && reg_addr == imb_pkg::ADDR_LOW && !reg_wr)
        |=> reg_rd_valid && reg_rd_data == $past(reg_wr_data, 2))
        else $error("low mask readback mismatch");

    a_high_fixed_zero: assert property (
        mask_high[7] == 1'b0 && mask_high[5] == 1'b0)
        else $error("fixed bits of high mask set");

    a_request_drops: assert property (
        (src_pending & mask_all) == 24'h0 [*2] |=> !irq ##0 src_request == 24'h0)
        else $error("request stayed up with nothing enabled pending");

    a_read_answer: assert property (
        reg_rd |=> reg_rd_valid)
        else $error("read strobe got no valid answer");

    a_read_unmapped: assert property (
        reg_rd && reg_addr != imb_pkg::ADDR_LOW && reg_addr != imb_pkg::ADDR_MIDDLE
        && reg_addr != imb_pkg::ADDR_HIGH |=> reg_rd_data == imb_pkg::READ_UNMAPPED)
        else $error("unmapped read returned nonzero data");

    c_low_irq: cover property (wr_low ##1 (|(src_pending & mask_all)) ##1 irq);
    c_mask_blocks: cover property (src_pending != 24'h0 && mask_all == 24'h0 ##1 !irq);
    c_high_write: cover property (wr_high && reg_wr_data == 8'hFF ##1 mask_high == 8'h5F);
    c_read_unmapped: cover property (reg_rd && reg_addr == 8'h46 ##1 reg_rd_valid);
    c_monitor_irq: cover property (src_pending == 24'h008000 ##1 irq);
endmodule

// ==== test/imb_mask_bank_bench.sv ====
// self-checking bench for the interrupt enable mask bank
// assumes the byte register port of the design; inputs change on the falling edge
`timescale 1ns/1ps
module imb_mask_bank_bench;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rd_data;
    logic reg_rd_valid;
    logic [23:0] src_pending = 24'h000000;
    logic irq;
    logic [23:0] src_request;
    logic [23:0] mask_out;
    int err_total = 0;
    int n_checks = 0;

    always #5 clock = ~clock;

    imb_mask_bank i_imb_mask_bank (
        .clock(clock),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wr_data(reg_wr_data),
        .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid),
        .src_pending(src_pending),
        .irq(irq),
        .src_request(src_request),
        .mask_out(mask_out)
    );

    task automatic chk_vec(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        chk_vec(name, {16'h0000, exp}, {16'h0000, got});
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    // leaves the strobe high so writes can follow back to back; idle() drops it
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        reg_addr = addr;
        reg_wr_data = data;
        reg_wr = 1'b1;
        @(negedge clock);
    endtask

    task automatic idle();
        reg_wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        reg_addr = addr;
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge clock);
        // valid stands for this one cycle only, so look before the next edge
        reg_rd = 1'b0;
        chk_bit("reg_rd_valid", 1'b1, reg_rd_valid);
        chk_byte("reg_rd_data", exp, reg_rd_data);
        @(negedge clock);
    endtask

    // walks a single enable bit through one byte with every source pending
    task automatic byte_test(input logic [7:0] addr, input int base, input logic [7:0] wmask);
        logic [7:0] bit_val;
        logic [23:0] exp;
        for (int b = 0; b < 8; b++) begin
            bit_val = (8'h01 << b) & wmask;
            exp = {16'h0000, bit_val} << base;
            wr(addr, 8'h01 << b);
            reg_wr = 1'b0;
            src_pending = 24'hFFFFFF;
            @(negedge clock);
            chk_vec("src_request", exp, src_request);
            chk_bit("irq", |exp, irq);
            chk_vec("mask_out", exp, mask_out);
            // the enabled source alone goes quiet, so the request must drop
            src_pending = ~exp;
            @(negedge clock);
            chk_bit("irq_quiet", 1'b0, irq);
            rd(addr, bit_val);
        end
        wr(addr, 8'h00);
        idle();
        $display("test byte %h done", addr);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // the whole sequence needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        print_verdict();
    end

    initial begin
        repeat (16) @(negedge clock);
        arst_n = 1'b1;
        @(negedge clock);
        chk_vec("mask_out", 24'h000000, mask_out);
        rd(imb_pkg::ADDR_LOW, imb_pkg::RESET_LOW);
        rd(imb_pkg::ADDR_MIDDLE, imb_pkg::RESET_MIDDLE);
        rd(imb_pkg::ADDR_HIGH, imb_pkg::RESET_HIGH);
        src_pending = 24'hFFFFFF;
        @(negedge clock);
        chk_bit("irq", 1'b0, irq);
        $display("test reset done");
        byte_test(imb_pkg::ADDR_LOW, imb_pkg::LOW_BASE, 8'hFF);
        byte_test(imb_pkg::ADDR_MIDDLE, imb_pkg::MIDDLE_BASE, 8'hFF);
        byte_test(imb_pkg::ADDR_HIGH, imb_pkg::HIGH_BASE, imb_pkg::WRITABLE_HIGH);
        // back to back writes, then stray writes that must leave the bank alone
        wr(imb_pkg::ADDR_LOW, 8'hFF);
        wr(imb_pkg::ADDR_MIDDLE, 8'hFF);
        wr(imb_pkg::ADDR_HIGH, 8'hFF);
        wr(8'h46, 8'h00);
        wr(8'h42, 8'h00);
        idle();
        src_pending = 24'h400000;
        @(negedge clock);
        chk_vec("mask_out", 24'h5FFFFF, mask_out);
        chk_bit("irq", 1'b1, irq);
        rd(8'h42, imb_pkg::READ_UNMAPPED);
        // read and write in one cycle: the read returns the old value
        reg_addr = imb_pkg::ADDR_LOW;
        reg_wr_data = 8'hA5;
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        @(negedge clock);
        chk_byte("reg_rd_data", 8'hFF, reg_rd_data);
        rd(imb_pkg::ADDR_LOW, 8'hA5);
        $display("test bank access done");
        // reset in mid-run clears every enable
        arst_n = 1'b0;
        repeat (2) @(negedge clock);
        chk_vec("mask_out", 24'h000000, mask_out);
        chk_bit("irq", 1'b0, irq);
        arst_n = 1'b1;
        @(negedge clock);
        rd(imb_pkg::ADDR_LOW, 8'h00);
        rd(imb_pkg::ADDR_HIGH, 8'h00);
        $display("test second reset done");
        // lone sources against zero masks, then one monitor enable
        src_pending = 24'h0000E0;
        @(negedge clock);
        chk_bit("irq", 1'b0, irq);
        src_pending = 24'h100000;
        @(negedge clock);
        chk_bit("irq", 1'b0, irq);
        src_pending = 24'h008000;
        @(negedge clock);
        chk_bit("irq", 1'b0, irq);
        wr(imb_pkg::ADDR_MIDDLE, 8'h80);
        idle();
        chk_vec("src_request", 24'h008000, src_request);
        chk_bit("irq", 1'b1, irq);
        // read straight after write sees the new value
        wr(imb_pkg::ADDR_LOW, 8'h3C);
        rd(imb_pkg::ADDR_LOW, 8'h3C);
        rd(8'h46, imb_pkg::READ_UNMAPPED);
        $display("test lone sources done");
        print_verdict();
    end
endmodule
